// [logic/iin_cal_consts.vh]
// command codes, reset values and fixed figures for the calibration slice
`ifndef IIN_CAL_CONSTS_VH
`define IIN_CAL_CONSTS_VH
`define CMD_FORMAT_BYTE   8'h20
`define CMD_SETPOINT      8'h21
`define CMD_CEILING       8'h24
`define CMD_MARGIN_HIGH   8'h25
`define CMD_MARGIN_LOW    8'h26
`define CMD_OV_FAULT      8'h40
`define CMD_OV_WARN       8'h42
`define CMD_UV_WARN       8'h43
`define CMD_UV_FAULT      8'h44
`define CMD_PG_ON         8'h5E
`define CMD_PG_OFF        8'h5F
`define CMD_EIN_CONFIG    8'hC1
`define CMD_GAIN_TEMPCO   8'hC3
`define CMD_CLEAR_ENERGY  8'hCC
`define CMD_STARTUP_DAC   8'hCD
`define CMD_DIRECT_DAC    8'hE0
`define CMD_SENSE_GAIN    8'hE8
`define CMD_DISCHARGE     8'hE9
`define FMT_TYPE_LINEAR   3'h0
`define FMT_EXPONENT      5'h13
`define RST_SETPOINT      16'h2000
`define RST_CEILING       16'h8000
`define RST_MARGIN_HIGH   16'h219A
`define RST_MARGIN_LOW    16'h1E66
`define RST_OV_FAULT      16'h2333
`define RST_OV_WARN       16'h2266
`define RST_UV_WARN       16'h1D9A
`define RST_UV_FAULT      16'h1CCD
`define RST_PG_ON         16'h1EB8
`define RST_PG_OFF        16'h1E14
`define RST_DISCHARGE     16'hC200
`define RST_DAC           16'h0000
`define RST_SENSE_GAIN    16'hBA00
`define RST_TEMPCO        16'h0000
`define RST_EIN_CONFIG    8'h00
`define DAC_BITS          10
`define RANGE_HIGH        2'h0
`define RANGE_MEDIUM      2'h1
`define RANGE_LOW         2'h2
`define RANGE_RESERVED    2'h3
// sense gain clamp in micro-ohm: 0.01 mohm .. 1000 mohm
`define GAIN_MIN_UOHM     32'h0000000A
`define GAIN_MAX_UOHM     32'h000F4240
// thermal factor in Q16: 0.25 .. 4.0, 1.0 = 0x10000
`define TCORR_ONE         32'h00010000
`define TCORR_MIN         32'h00004000
`define TCORR_MAX         32'h00040000
// die temperature in 1/16 degC, 25.0 degC = 400
`define TEMP_OFFSET_25C   16'h0190
`endif

// [logic/iin_cal_vout_limit_regs.v]
// command register slice: input current calibration and output voltage limits
`timescale 1ns/1ps
`include "iin_cal_consts.vh"
module iin_cal_vout_limit_regs #(
  parameter CHANNELS = 2
) (
  // clock and reset
  input  wire                 clk,
  input  wire                 rst_b,
  // command port from the bus engine, same clock
  input  wire                 cmd_wr,
  input  wire                 cmd_rd,
  input  wire                 cmd_send,
  input  wire [7:0]           cmd_code,
  input  wire                 cmd_page,
  input  wire [15:0]          cmd_wdata,
  input  wire [1:0]           write_protect,
  output reg  [15:0]          cmd_rdata,
  output reg                  cmd_ack,
  // measurements from the converter, same clock
  input  wire                 adc_update,
  input  wire signed [15:0]   die_temp,
  input  wire signed [23:0]   sense_uv,
  input  wire [15:0]          vout_meas0,
  input  wire [15:0]          vout_meas1,
  input  wire                 ramp_active0,
  input  wire                 ramp_active1,
  input  wire [1:0]           margin_sel0,
  input  wire [1:0]           margin_sel1,
  input  wire                 pg_off_from_undervoltage,
  // results
  output reg  signed [23:0]   iin_reading,
  output reg  [31:0]          thermal_correction_factor,
  output reg                  energy_clear,
  output reg  [1:0]           iin_range,
  output reg  [CHANNELS-1:0]  power_good,
  output reg  [CHANNELS-1:0]  ton_fault,
  output reg  [CHANNELS-1:0]  discharge_pending,
  output reg  [31:0]          vout_target,
  output reg  [`DAC_BITS-1:0] dac_code
);

  // paged registers, one word per channel
  reg [15:0] output_setpoint          [0:CHANNELS-1];
  reg [15:0] output_ceiling           [0:CHANNELS-1];
  reg [15:0] margin_high_level        [0:CHANNELS-1];
  reg [15:0] margin_low_level         [0:CHANNELS-1];
  reg [15:0] overvoltage_fault_level  [0:CHANNELS-1];
  reg [15:0] overvoltage_warn_level   [0:CHANNELS-1];
  reg [15:0] undervoltage_warn_level  [0:CHANNELS-1];
  reg [15:0] undervoltage_fault_level [0:CHANNELS-1];
  reg [15:0] pg_assert_level          [0:CHANNELS-1];
  reg [15:0] pg_deassert_level        [0:CHANNELS-1];
  reg [15:0] startup_dac_code         [0:CHANNELS-1];
  reg [15:0] discharge_coefficient    [0:CHANNELS-1];
  // unpaged registers
  reg [15:0] direct_dac_code;
  reg [15:0] input_sense_gain;
  reg [15:0] input_gain_tempco_field;
  reg [7:0]  ein_config;
  reg        clear_pending;

  wire [15:0] vmeas [0:CHANNELS-1];
  wire        ramp  [0:CHANNELS-1];
  wire [1:0]  msel  [0:CHANNELS-1];
  assign vmeas[0] = vout_meas0;
  assign vmeas[1] = vout_meas1;
  assign ramp[0]  = ramp_active0;
  assign ramp[1]  = ramp_active1;
  assign msel[0]  = margin_sel0;
  assign msel[1]  = margin_sel1;

  // L11 value to micro-units: mantissa * 1000 * 2^exp, exp in [-16,15]
  function [31:0] l11_to_micro;
    input [15:0] v;
    reg signed [10:0] man;
    reg signed [4:0]  ex;
    reg signed [47:0] prod;
    begin
      man  = v[10:0];
      ex   = v[15:11];
      prod = $signed({{37{man[10]}}, man}) * 48'sd1000;
      if (ex[4])
        prod = prod >>> (-ex);
      else
        prod = prod <<< ex;
      l11_to_micro = prod[31:0];
    end
  endfunction

  // L11 coefficient times L16 word, result stays in L16 units
  function [31:0] l11_times_l16;
    input [15:0] c;
    input [15:0] w;
    reg signed [10:0] man;
    reg signed [4:0]  ex;
    reg signed [47:0] prod;
    begin
      man  = c[10:0];
      ex   = c[15:11];
      prod = $signed({{37{man[10]}}, man}) * $signed({32'h0, w});
      if (ex[4])
        prod = prod >>> (-ex);
      else
        prod = prod <<< ex;
      // a negative coefficient means no threshold; floor it at zero
      if (prod < 0)
        l11_times_l16 = 32'h0;
      else
        l11_times_l16 = prod[31:0];
    end
  endfunction

  // clamped gain and saturated thermal factor
  reg [31:0]        gain_raw;
  reg [31:0]        gain_clamped;
  reg signed [47:0] tc_term;
  reg signed [47:0] tc_full;
  reg [31:0]        next_tcorr;
  reg signed [63:0] denom;
  always @*
  begin
    gain_raw = l11_to_micro(input_sense_gain);
    if ($signed(gain_raw) < $signed(`GAIN_MIN_UOHM))
      gain_clamped = `GAIN_MIN_UOHM;
    else if ($signed(gain_raw) > $signed(`GAIN_MAX_UOHM))
      gain_clamped = `GAIN_MAX_UOHM;
    else
      gain_clamped = gain_raw;
    // tempco(ppm) * dT(1/16 C) * 2^16 / 16 / 1e6
    // both operands widened first so the product cannot wrap
    tc_term = $signed({{32{input_gain_tempco_field[15]}},
                       input_gain_tempco_field})
            * ($signed({{32{die_temp[15]}}, die_temp})
               - $signed({32'h0, `TEMP_OFFSET_25C}));
    tc_full = (tc_term * 48'sd4096) / 48'sd1000000;
    tc_full = tc_full + $signed({16'h0, `TCORR_ONE});
    if (tc_full < $signed({16'h0, `TCORR_MIN}))
      next_tcorr = `TCORR_MIN;
    else if (tc_full > $signed({16'h0, `TCORR_MAX}))
      next_tcorr = `TCORR_MAX;
    else
      next_tcorr = tc_full[31:0];
    denom = $signed({32'h0, gain_clamped})
          * $signed({32'h0, next_tcorr});
  end

  // gain in micro-ohm, factor in Q16: I(mA) = uV*1e3*2^16 / (uohm*Q16)
  reg signed [63:0] num;
  always @*
  begin
    num = $signed({{40{sense_uv[23]}}, sense_uv}) * 64'sd65536000;
  end

  // divisor never zero: gain and factor floors are both positive
  wire signed [63:0] quotient = num / denom;

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      iin_reading               <= 24'h000000;
      thermal_correction_factor <= `TCORR_ONE;
    end
    else if (adc_update)
    begin
      thermal_correction_factor <= next_tcorr;
      iin_reading               <= quotient[23:0];
    end
  end

  wire pg_idx = cmd_page;
  wire prot = (write_protect != 2'h0);

  // writes and energy clear
  integer i;
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (i = 0; i < CHANNELS; i = i + 1)
      begin
        output_setpoint[i]          <= `RST_SETPOINT;
        output_ceiling[i]           <= `RST_CEILING;
        margin_high_level[i]        <= `RST_MARGIN_HIGH;
        margin_low_level[i]         <= `RST_MARGIN_LOW;
        overvoltage_fault_level[i]  <= `RST_OV_FAULT;
        overvoltage_warn_level[i]   <= `RST_OV_WARN;
        undervoltage_warn_level[i]  <= `RST_UV_WARN;
        undervoltage_fault_level[i] <= `RST_UV_FAULT;
        pg_assert_level[i]          <= `RST_PG_ON;
        pg_deassert_level[i]        <= `RST_PG_OFF;
        startup_dac_code[i]         <= `RST_DAC;
        discharge_coefficient[i]    <= `RST_DISCHARGE;
      end
      direct_dac_code         <= `RST_DAC;
      input_sense_gain        <= `RST_SENSE_GAIN;
      input_gain_tempco_field <= `RST_TEMPCO;
      ein_config              <= `RST_EIN_CONFIG;
      clear_pending           <= 1'b0;
      energy_clear            <= 1'b0;
    end
    else
    begin
      energy_clear <= 1'b0;
      // clear waits for next ADC update so no calculation is torn
      if (clear_pending && adc_update)
      begin
        energy_clear  <= 1'b1;
        clear_pending <= 1'b0;
      end
      // protection does not gate the clear command
      if (cmd_send && cmd_code == `CMD_CLEAR_ENERGY)
        clear_pending <= 1'b1;
      if (cmd_wr && !prot)
      begin
        case (cmd_code)
          `CMD_SETPOINT:     output_setpoint[pg_idx]          <= cmd_wdata;
          `CMD_CEILING:      output_ceiling[pg_idx]           <= cmd_wdata;
          `CMD_MARGIN_HIGH:  margin_high_level[pg_idx]        <= cmd_wdata;
          `CMD_MARGIN_LOW:   margin_low_level[pg_idx]         <= cmd_wdata;
          `CMD_OV_FAULT:     overvoltage_fault_level[pg_idx]  <= cmd_wdata;
          `CMD_OV_WARN:      overvoltage_warn_level[pg_idx]   <= cmd_wdata;
          `CMD_UV_WARN:      undervoltage_warn_level[pg_idx]  <= cmd_wdata;
          `CMD_UV_FAULT:     undervoltage_fault_level[pg_idx] <= cmd_wdata;
          `CMD_PG_ON:        pg_assert_level[pg_idx]          <= cmd_wdata;
          `CMD_PG_OFF:       pg_deassert_level[pg_idx]        <= cmd_wdata;
          `CMD_STARTUP_DAC:
            startup_dac_code[pg_idx] <= {6'h00, cmd_wdata[9:0]};
          `CMD_DISCHARGE:    discharge_coefficient[pg_idx]    <= cmd_wdata;
          `CMD_DIRECT_DAC:
            direct_dac_code <= {6'h00, cmd_wdata[9:0]};
          `CMD_SENSE_GAIN:   input_sense_gain        <= cmd_wdata;
          `CMD_GAIN_TEMPCO:  input_gain_tempco_field <= cmd_wdata;
          `CMD_EIN_CONFIG:
          begin
            // a range change restarts energy and time accumulation
            ein_config    <= {5'h00, cmd_wdata[2:0]};
            clear_pending <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // reads; format byte is constant and has no write path
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cmd_rdata <= 16'h0000;
      cmd_ack   <= 1'b0;
    end
    else
    begin
      // refused writes are still acknowledged so the host never stalls
      cmd_ack <= cmd_rd | cmd_wr | cmd_send;
      if (cmd_rd)
      begin
        case (cmd_code)
          `CMD_FORMAT_BYTE:
            cmd_rdata <= {8'h00, `FMT_TYPE_LINEAR, `FMT_EXPONENT};
          `CMD_SETPOINT:     cmd_rdata <= output_setpoint[pg_idx];
          `CMD_CEILING:      cmd_rdata <= output_ceiling[pg_idx];
          `CMD_MARGIN_HIGH:  cmd_rdata <= margin_high_level[pg_idx];
          `CMD_MARGIN_LOW:   cmd_rdata <= margin_low_level[pg_idx];
          `CMD_OV_FAULT:     cmd_rdata <= overvoltage_fault_level[pg_idx];
          `CMD_OV_WARN:      cmd_rdata <= overvoltage_warn_level[pg_idx];
          `CMD_UV_WARN:      cmd_rdata <= undervoltage_warn_level[pg_idx];
          `CMD_UV_FAULT:     cmd_rdata <= undervoltage_fault_level[pg_idx];
          `CMD_PG_ON:        cmd_rdata <= pg_assert_level[pg_idx];
          `CMD_PG_OFF:       cmd_rdata <= pg_deassert_level[pg_idx];
          `CMD_STARTUP_DAC:  cmd_rdata <= startup_dac_code[pg_idx];
          `CMD_DISCHARGE:    cmd_rdata <= discharge_coefficient[pg_idx];
          `CMD_DIRECT_DAC:   cmd_rdata <= direct_dac_code;
          `CMD_SENSE_GAIN:   cmd_rdata <= input_sense_gain;
          `CMD_GAIN_TEMPCO:  cmd_rdata <= input_gain_tempco_field;
          `CMD_EIN_CONFIG:   cmd_rdata <= {8'h00, ein_config};
          default:           cmd_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // per-channel supervision
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1)
    begin : chan
      wire [15:0] off_lvl = pg_off_from_undervoltage ?
                            undervoltage_fault_level[g] :
                            pg_deassert_level[g];
      wire [31:0] off_thr = l11_times_l16(discharge_coefficient[g],
                                          output_setpoint[g]);
      always @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          power_good[g]        <= 1'b0;
          ton_fault[g]         <= 1'b0;
          discharge_pending[g] <= 1'b0;
        end
        else
        begin
          // levels may overlap after a write; assertion takes priority
          if (vmeas[g] >= pg_assert_level[g])
            power_good[g] <= 1'b1;
          else if (vmeas[g] <= off_lvl)
            power_good[g] <= 1'b0;
          ton_fault[g] <= ramp[g] &&
                          (vmeas[g] <= undervoltage_fault_level[g]);
          discharge_pending[g] <= ({16'h0, vmeas[g]} >= off_thr);
        end
      end
    end
  endgenerate

  // servo target of channel 0, mantissa at 2^-13 per lsb
  reg [15:0] sel_target;
  always @*
  begin
    case (msel[0])
      2'h1:    sel_target = margin_high_level[0];
      2'h2:    sel_target = margin_low_level[0];
      default: sel_target = output_setpoint[0];
    endcase
    // margins obey the ceiling too; a high margin never lifts past it
    if (sel_target > output_ceiling[0])
      sel_target = output_ceiling[0];
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      vout_target <= 32'h0;
      dac_code    <= {`DAC_BITS{1'b0}};
      iin_range   <= `RANGE_HIGH;
    end
    else
    begin
      vout_target <= {16'h0, sel_target};
      dac_code    <= direct_dac_code[`DAC_BITS-1:0];
      // reserved code keeps the last legal range rather than guessing
      if (ein_config[1:0] != `RANGE_RESERVED)
        iin_range <= ein_config[1:0];
    end
  end

endmodule // iin_cal_vout_limit_regs

// [sim/iin_cal_vout_limit_regs_sva.sv]
// assertion checker for the calibration and output limit slice
`timescale 1ns/1ps
`include "iin_cal_consts.vh"
module iin_cal_vout_limit_regs_sva #(
  parameter CHANNELS = 2
) (
  // clock and reset
  input wire                clk,
  input wire                rst_b,
  // command port
  input wire                cmd_wr,
  input wire                cmd_rd,
  input wire                cmd_send,
  input wire [7:0]          cmd_code,
  input wire [15:0]         cmd_rdata,
  input wire                cmd_ack,
  // measurements and results
  input wire                adc_update,
  input wire [15:0]         vout_meas0,
  input wire                pg_off_from_undervoltage,
  input wire [31:0]         thermal_correction_factor,
  input wire                energy_clear,
  input wire [1:0]          iin_range,
  input wire [CHANNELS-1:0] power_good
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_cmd;
    cmd_wr || cmd_rd || cmd_send;
  endsequence
  sequence s_fmt_read;
    cmd_rd && cmd_code == `CMD_FORMAT_BYTE;
  endsequence
  AST_ACK_AFTER_CMD: assert property (s_cmd |=> cmd_ack)
    else $error("no acknowledge after a command");
  AST_ACK_CAUSED: assert property (cmd_ack |-> $past(cmd_wr || cmd_rd || cmd_send))
    else $error("acknowledge without a command");
  AST_FORMAT_READ: assert property (s_fmt_read |=> cmd_rdata == 16'h0013)
    else $error("format byte read wrong");
  AST_TCORR_FLOOR: assert property (thermal_correction_factor >= `TCORR_MIN)
    else $error("thermal factor below floor");
  AST_TCORR_CEIL: assert property (thermal_correction_factor <= `TCORR_MAX)
    else $error("thermal factor above ceiling");
  AST_CLEAR_ON_TICK: assert property (energy_clear |-> $past(adc_update))
    else $error("energy clear not aligned to a converter tick");
  AST_CLEAR_PULSE: assert property (energy_clear |=> !energy_clear)
    else $error("energy clear longer than one cycle");
  AST_RANGE_LEGAL: assert property (iin_range != `RANGE_RESERVED)
    else $error("reserved range applied");
  AST_PG_RISE: assert property ($rose(power_good[0]) |-> $past(vout_meas0) >= `RST_PG_ON)
    else $error("power good rose below assert level");
  AST_PG_FALL_OFF: assert property ($fell(power_good[0]) && !pg_off_from_undervoltage
    |-> $past(vout_meas0) <= `RST_PG_OFF)
    else $error("power good fell above off level");
  AST_PG_FALL_UV: assert property ($fell(power_good[0]) && pg_off_from_undervoltage
    |-> $past(vout_meas0) <= `RST_UV_FAULT)
    else $error("power good fell above undervoltage level");
endmodule // iin_cal_vout_limit_regs_sva
bind iin_cal_vout_limit_regs iin_cal_vout_limit_regs_sva #(.CHANNELS(CHANNELS))
  u_sva (.clk(clk), .rst_b(rst_b), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
  .cmd_send(cmd_send), .cmd_code(cmd_code), .cmd_rdata(cmd_rdata),
  .cmd_ack(cmd_ack), .adc_update(adc_update), .vout_meas0(vout_meas0),
  .pg_off_from_undervoltage(pg_off_from_undervoltage),
  .thermal_correction_factor(thermal_correction_factor),
  .energy_clear(energy_clear), .iin_range(iin_range),
  .power_good(power_good));

// [sim/host_cmd_model.sv]
// host side model issuing write, read and send-byte commands
`timescale 1ns/1ps
module host_cmd_model (
  // clock
  input wire        clk,
  // command strobes and payload
  output reg        cmd_wr,
  output reg        cmd_rd,
  output reg        cmd_send,
  output reg [7:0]  cmd_code,
  output reg        cmd_page,
  output reg [15:0] cmd_wdata
);
  initial
  begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_send = 1'b0;
    cmd_code = 8'h00;
    cmd_page = 1'b0;
    cmd_wdata = 16'h0000;
  end
  // kind 1 write, 2 read, 3 send byte; page and word go out together
  task op(input [1:0] kind, input [7:0] code, input page, input [15:0] data);
    begin
      @(negedge clk);
      cmd_wr = (kind == 2'h1);
      cmd_rd = (kind == 2'h2);
      cmd_send = (kind == 2'h3);
      cmd_code = code;
      cmd_page = page;
      cmd_wdata = data;
      @(negedge clk);
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
      cmd_send = 1'b0;
      // flipped once released, so stale payload never looks valid
      cmd_code = ~code;
      cmd_wdata = ~data;
    end
  endtask
endmodule // host_cmd_model

// [sim/iin_cal_vout_limit_regs_test.sv]
// self-checking bench for the calibration and output limit slice
`timescale 1ns/1ps
`include "iin_cal_consts.vh"
module iin_cal_vout_limit_regs_test;
  reg               clk, rst_b, adc_update, ramp_active0, pg_off_from_undervoltage;
  reg [1:0]         write_protect, margin_sel0;
  reg signed [15:0] die_temp;
  reg signed [23:0] sense_uv;
  reg [15:0]        vout_meas0, vout_meas1, v;
  wire              cmd_wr, cmd_rd, cmd_send, cmd_page, cmd_ack, energy_clear;
  wire [7:0]        cmd_code;
  wire [15:0]       cmd_wdata, cmd_rdata;
  wire signed [23:0] iin_reading;
  wire [31:0]       thermal_correction_factor, vout_target;
  wire [1:0]        iin_range, power_good, ton_fault, discharge_pending;
  wire [9:0]        dac_code;
  integer           n_mismatch = 0, comparisons = 0, n_clear = 0;
  integer           seed = 36893, i, j;
  logic [16:0]      exp_q[$];
  logic [16:0]      e;
  logic [7:0]  codes [0:15] = '{8'h21, 8'h24, 8'h25, 8'h26, 8'h40, 8'h42,
    8'h43, 8'h44, 8'h5E, 8'h5F, 8'hCD, 8'hE9, 8'hC3, 8'hE8, 8'hE0, 8'h20};
  logic [15:0] defs [0:15] = '{16'h2000, 16'h8000, 16'h219A, 16'h1E66,
    16'h2333, 16'h2266, 16'h1D9A, 16'h1CCD, 16'h1EB8, 16'h1E14, 16'h0000,
    16'hC200, 16'h0000, 16'hBA00, 16'h0000, 16'h0013};
  logic [15:0] pgv [0:5] = '{16'h1EB8, 16'h1E15, 16'h1E14, 16'h1EB8,
    16'h1E00, 16'h1CCD};
  logic        pge [0:5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

  host_cmd_model u_host_cmd_model (.clk(clk), .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd), .cmd_send(cmd_send), .cmd_code(cmd_code),
    .cmd_page(cmd_page), .cmd_wdata(cmd_wdata));
  iin_cal_vout_limit_regs u_iin_cal_vout_limit_regs (.clk(clk),
    .rst_b(rst_b), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_send(cmd_send),
    .cmd_code(cmd_code), .cmd_page(cmd_page), .cmd_wdata(cmd_wdata),
    .write_protect(write_protect), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack),
    .adc_update(adc_update), .die_temp(die_temp), .sense_uv(sense_uv),
    .vout_meas0(vout_meas0), .vout_meas1(vout_meas1),
    .ramp_active0(ramp_active0), .ramp_active1(1'b0),
    .margin_sel0(margin_sel0), .margin_sel1(2'h0),
    .pg_off_from_undervoltage(pg_off_from_undervoltage),
    .iin_reading(iin_reading),
    .thermal_correction_factor(thermal_correction_factor),
    .energy_clear(energy_clear), .iin_range(iin_range),
    .power_good(power_good), .ton_fault(ton_fault),
    .discharge_pending(discharge_pending), .vout_target(vout_target),
    .dac_code(dac_code));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task check(input string name, input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task rd(input [7:0] c, input p, input [15:0] x);
    begin
      exp_q.push_back({1'b1, x});
      u_host_cmd_model.op(2'h2, c, p, 16'h0000);
    end
  endtask
  task wr(input [7:0] c, input p, input [15:0] d);
    begin
      exp_q.push_back(17'h00000);
      u_host_cmd_model.op(2'h1, c, p, d);
    end
  endtask
  // one converter tick, then time for the results to land
  task settle;
    begin
      @(negedge clk);
      adc_update = 1'b1;
      @(negedge clk);
      adc_update = 1'b0;
      repeat (3) @(negedge clk);
    end
  endtask
  task end_of_test;
    begin
      if (n_mismatch == 0 && comparisons > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  // scoreboard: every acknowledge retires the oldest note
  always @(negedge clk)
  begin
    if (cmd_ack === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("unexpected ack", 32'h1, 32'h0);
      else
      begin
        e = exp_q.pop_front();
        if (e[16])
          check("cmd_rdata", {16'h0, cmd_rdata}, {16'h0, e[15:0]});
      end
    end
    if (energy_clear === 1'b1)
      n_clear = n_clear + 1;
  end

  initial
  begin
    #400000;
    n_mismatch = n_mismatch + 1;
    end_of_test;
  end

  initial
  begin
    rst_b = 1'b0;
    adc_update = 1'b0;
    ramp_active0 = 1'b0;
    pg_off_from_undervoltage = 1'b0;
    write_protect = 2'h0;
    margin_sel0 = 2'h0;
    die_temp = 16'sh0190;
    sense_uv = 24'sh000000;
    vout_meas0 = 16'h0000;
    vout_meas1 = 16'h0000;
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    for (i = 0; i < 32; i = i + 1)
      rd(codes[i/2], i[0], defs[i/2]);
    wr(`CMD_FORMAT_BYTE, 1'b0, 16'hFFFF);
    rd(`CMD_FORMAT_BYTE, 1'b0, 16'h0013);
    // paged codes come first in the table, unpaged ones take the last write
    for (i = 0; i < 15; i = i + 1)
    begin
      v = $random(seed);
      vout_meas1 = $random(seed);
      wr(codes[i], 1'b0, v);
      wr(codes[i], 1'b1, ~v);
      rd(codes[i], 1'b0, (i < 12 ? v : ~v) & (i == 10 || i == 14 ? 16'h03FF : 16'hFFFF));
      wr(codes[i], 1'b0, defs[i]);
      wr(codes[i], 1'b1, defs[i]);
    end
    write_protect = 2'h2;
    wr(`CMD_SETPOINT, 1'b0, 16'h1234);
    rd(`CMD_SETPOINT, 1'b0, `RST_SETPOINT);
    n_clear = 0;
    exp_q.push_back(17'h00000);
    u_host_cmd_model.op(2'h3, `CMD_CLEAR_ENERGY, 1'b0, 16'h0000);
    repeat (6) @(negedge clk);
    check("early clear", n_clear, 0);
    settle;
    check("clear pulses", n_clear, 1);
    write_protect = 2'h0;
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(`CMD_EIN_CONFIG, 1'b0, i[15:0]);
      repeat (2) @(negedge clk);
      check("iin_range", iin_range, i == 3 ? 2 : i);
    end
    wr(`CMD_DIRECT_DAC, 1'b1, 16'hFFFF);
    repeat (2) @(negedge clk);
    check("dac_code", dac_code, 10'h3FF);
    ramp_active0 = 1'b1;
    for (i = 0; i < 3; i = i + 1)
    begin
      wr(`CMD_GAIN_TEMPCO, 1'b0, i == 0 ? 16'h7FFF : i == 1 ? 16'h8000 : 16'h0000);
      die_temp = i < 2 ? 16'sh0C80 : $random(seed);
      sense_uv = $random(seed) % 1000000;
      settle;
      check("thermal factor", thermal_correction_factor, i == 0 ? `TCORR_MAX : i == 1 ? `TCORR_MIN : `TCORR_ONE);
    end
    // unit gain and unit factor: one microvolt reads as one milliamp
    check("iin_reading", iin_reading, sense_uv);
    check("ton_fault", ton_fault[0], 1'b1);
    ramp_active0 = 1'b0;
    for (i = 0; i < 6; i = i + 1)
    begin
      pg_off_from_undervoltage = i > 2;
      ramp_active0 = i[0];
      vout_meas0 = pgv[i];
      settle;
      check("power_good", power_good[0], pge[i]);
      check("ton_fault", ton_fault[0], i[0] && pgv[i] <= `RST_UV_FAULT);
    end
    wr(`CMD_CEILING, 1'b0, 16'h2100);
    for (i = 0; i < 3; i = i + 1)
    begin
      margin_sel0 = i[1:0];
      settle;
      check("vout_target", vout_target, i == 0 ? 32'h2000 : i == 1 ? 32'h2100 : 32'h1E66);
    end
    // default coefficient 2.0 times default setpoint puts the line at 0x4000
    for (i = 0; i < 2; i = i + 1)
    begin
      vout_meas0 = 16'h3FFF + i[15:0];
      settle;
      check("discharge_pending", discharge_pending[0], i);
    end
    settle;
    end_of_test;
  end
endmodule // iin_cal_vout_limit_regs_test
